// [mct_regs.svh]
// register offsets, field positions, reset values and counts of the timer
`ifndef MCT_REGS_SVH
`define MCT_REGS_SVH

`define MCT_AW 4
`define MCT_DW 8
`define MCT_CW 16

`define MCT_ADDR_CTRL0 4'h0
`define MCT_ADDR_CTRL1 4'h1
`define MCT_ADDR_CNTL 4'h2
`define MCT_ADDR_CNTH 4'h3
`define MCT_ADDR_CMPL 4'h4
`define MCT_ADDR_CMPH 4'h5
`define MCT_ADDR_CAPL 4'h6
`define MCT_ADDR_CAPH 4'h7
`define MCT_ADDR_FLAGS 4'h8

`define MCT_CTRL0_RST 8'h00
`define MCT_CTRL1_RST 8'h00
`define MCT_CTRL0_WMASK 8'hFB
`define MCT_BYTE_ZERO 8'h00
`define MCT_CNT_ZERO 16'h0000
`define MCT_CNT_ONE 16'h0001
`define MCT_CNT_MAX 16'hFFFF

`define MCT_FLAG_OVF 0
`define MCT_FLAG_MATCH 1

`define MCT_PRE_W 7
`define MCT_PRE_ZERO 7'h00
`define MCT_PRE_ONE 7'h01
`define MCT_DIV4_ZERO 2'h0
`define MCT_DIV4_ONE 2'h1
`define MCT_DIV4_LAST 2'h3
`define MCT_HIST_ZERO 4'h0

`endif

// [mct_pkg.sv]
// types shared by the motor capture/compare timer
`default_nettype none
package mct_pkg;

  typedef enum logic [1:0] {
    MCT_EDGE_OFF  = 2'b00,
    MCT_EDGE_RISE = 2'b01,
    MCT_EDGE_FALL = 2'b10,
    MCT_EDGE_BOTH = 2'b11
  } mct_edge_t;

  typedef enum logic [1:0] {
    MCT_SRC_A    = 2'b00,
    MCT_SRC_B    = 2'b01,
    MCT_SRC_C    = 2'b10,
    MCT_SRC_RSVD = 2'b11
  } mct_src_t;

  typedef struct packed {
    logic counter_pause;
    logic [2:0] counter_clock_select;
    logic timer_power_on;
    logic unused_bit;
    mct_src_t capture_source_select;
  } mct_ctrl0_t;

  typedef struct packed {
    mct_edge_t capture_edge_select;
    logic capture_input_enable;
    logic filter_sample_count;
    logic filter_clock_select;
    logic input_filter_enable;
    logic clear_on_capture;
    logic clear_on_match;
  } mct_ctrl1_t;

endpackage
`default_nettype wire

// [mct_in_filter.sv]
// synchroniser and optional consecutive-sample noise filter for one input
`timescale 1ns/1ps
`default_nettype none
`include "mct_regs.svh"

module mct_in_filter (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic pin_i,
  input wire logic filter_on_i,
  input wire logic sample_en_i,
  input wire logic four_samples_i,
  output logic level_o
);
  logic sync1_q;
  logic sync2_q;
  logic [3:0] hist_q;
  logic [3:0] hist_d;
  logic level_q;
  wire all_two;
  wire all_four;

  assign hist_d = {hist_q[2:0], sync2_q};
  assign all_two = (hist_d[1:0] == 2'b00) || (hist_d[1:0] == 2'b11);
  assign all_four = (hist_d == 4'h0) || (hist_d == 4'hF);
  assign level_o = level_q;

  // sync1_q is read only by sync2_q
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
    end else begin
      sync1_q <= pin_i;
      sync2_q <= sync1_q;
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      hist_q <= `MCT_HIST_ZERO;
      level_q <= 1'b0;
    end else if (!filter_on_i) begin
      hist_q <= {4{sync2_q}};
      level_q <= sync2_q;
    end else if (sample_en_i) begin
      hist_q <= hist_d;
      if (four_samples_i ? all_four : all_two) begin
        level_q <= hist_d[0]; // RULE7
      end
    end
  end

  chk_filter_bypass: assert property ( // RULE7
    @(posedge clk_i) disable iff (!reset_n_i)
    !filter_on_i |=> level_o == $past(sync2_q))
    else $error("unfiltered input does not follow synchroniser");

  chk_filter_hold: assert property ( // RULE7
    @(posedge clk_i) disable iff (!reset_n_i)
    filter_on_i && !sample_en_i |=> $stable(level_o))
    else $error("filtered level changed without a sample");

endmodule
`default_nettype wire

// [mct_timer.sv]
// motor capture/compare timer: counter, prescaler, capture, compare, regs
//
// Our own choices: the register offsets and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
`include "mct_regs.svh"

// What this block does, and what software does with it
// [RULE1] counter high byte readable, not writable, zero after reset
// [RULE2] 16-bit compare value in two read/write bytes, reset to zero
// [RULE3] 16-bit capture value in two read-only bytes
// [RULE4] three capture inputs, one chosen by source select
// [RULE5] capture on rising, falling or both edges; edge code zero disables
// [RULE6] power-on bit gates whole timer; capture enable gates triggers
// [RULE7] optional filter needs 2 or 4 equal samples at fsys or fsys/4
// [RULE8] free-running 16-bit up-counter advances per tick when on, unpaused
// [RULE9] valid trigger copies counter into capture value
// [RULE10] counter overflow sets overflow flag
// [RULE11] clear-on-capture zeroes counter after copy, counting continues
// [RULE12] counter equal to compare value sets match flag
// [RULE13] clear-on-match zeroes counter at each match
// [RULE14] software sets compare to longest edge gap, stops motor on match
// [RULE15] pause holds counter value; unpause resumes from it
// [RULE16] clock select code divides fsys by 1 to 128
// [RULE17] power-on rising zeroes counter; falling stops and keeps value
// [RULE18] source codes 00, 01, 10 pick inputs; 11 reserved
// [RULE19] counter wraps from all ones to zero and keeps counting
module mct_timer (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic [`MCT_AW-1:0] addr_i,
  input wire logic [`MCT_DW-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [`MCT_DW-1:0] rdata_o,
  input wire logic position_input_a_i,
  input wire logic position_input_b_i,
  input wire logic position_input_c_i,
  output logic counter_overflow_flag_o,
  output logic compare_match_flag_o
);
  import mct_pkg::*;

  mct_pkg::mct_ctrl0_t ctrl0_q;
  mct_pkg::mct_ctrl1_t ctrl1_q;
  logic [`MCT_CW-1:0] cnt_q;
  logic [`MCT_CW-1:0] cnt_d;
  logic [`MCT_CW-1:0] cmp_q;
  logic [`MCT_CW-1:0] cap_q;
  logic [`MCT_PRE_W-1:0] pre_q;
  logic [1:0] div4_q;
  logic power_prev_q;
  logic sel_prev_q;
  logic ovf_flag_q;
  logic match_flag_q;
  logic [`MCT_DW-1:0] rdata_q;
  logic [`MCT_DW-1:0] rdata_d;
  logic [2:0] filt_level;

  // ---------------------------------------------------------------
  // register decode
  // ---------------------------------------------------------------
  wire wr_ctrl0 = wr_i && (addr_i == `MCT_ADDR_CTRL0);
  wire wr_ctrl1 = wr_i && (addr_i == `MCT_ADDR_CTRL1);
  wire wr_cmpl = wr_i && (addr_i == `MCT_ADDR_CMPL);
  wire wr_cmph = wr_i && (addr_i == `MCT_ADDR_CMPH);
  wire wr_flags = wr_i && (addr_i == `MCT_ADDR_FLAGS);

  wire power_on = ctrl0_q.timer_power_on;
  wire power_rise = power_on && !power_prev_q;
  wire cnt_run = power_on && !ctrl0_q.counter_pause; // RULE15

  // ---------------------------------------------------------------
  // counter clock prescaler and filter sample divider
  // ---------------------------------------------------------------
  wire [`MCT_PRE_W-1:0] pre_mask =
    `MCT_PRE_W'((8'h01 << ctrl0_q.counter_clock_select) - 8'h01);
  wire pre_tick = power_on && ((pre_q & pre_mask) == pre_mask); // RULE16
  wire cnt_tick = cnt_run && pre_tick; // RULE8
  wire slow_sample = (div4_q == `MCT_DIV4_LAST);
  wire sample_en = ctrl1_q.filter_clock_select ? slow_sample : 1'b1;
  // filter only runs while the timer itself is on
  wire filter_on = power_on && ctrl1_q.input_filter_enable; // RULE7

  // prescaler restarts with the timer so the first tick is predictable
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pre_q <= `MCT_PRE_ZERO;
    end else if (!power_on || power_rise) begin
      pre_q <= `MCT_PRE_ZERO;
    end else begin
      pre_q <= pre_q + `MCT_PRE_ONE; // RULE16
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      div4_q <= `MCT_DIV4_ZERO;
    end else begin
      div4_q <= div4_q + `MCT_DIV4_ONE;
    end
  end

  // ---------------------------------------------------------------
  // capture inputs
  // ---------------------------------------------------------------
  mct_in_filter u_filt_a (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .pin_i(position_input_a_i),
    .filter_on_i(filter_on),
    .sample_en_i(sample_en),
    .four_samples_i(ctrl1_q.filter_sample_count),
    .level_o(filt_level[0])
  );

  mct_in_filter u_filt_b (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .pin_i(position_input_b_i),
    .filter_on_i(filter_on),
    .sample_en_i(sample_en),
    .four_samples_i(ctrl1_q.filter_sample_count),
    .level_o(filt_level[1])
  );

  mct_in_filter u_filt_c (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .pin_i(position_input_c_i),
    .filter_on_i(filter_on),
    .sample_en_i(sample_en),
    .four_samples_i(ctrl1_q.filter_sample_count),
    .level_o(filt_level[2])
  );

  wire src_valid = (ctrl0_q.capture_source_select != MCT_SRC_RSVD); // RULE18
  wire sel_level = src_valid ?
    filt_level[ctrl0_q.capture_source_select] : 1'b0; // RULE4
  wire edge_rise = sel_level && !sel_prev_q;
  wire edge_fall = !sel_level && sel_prev_q;
  wire edge_hit =
    (ctrl1_q.capture_edge_select[0] && edge_rise) ||
    (ctrl1_q.capture_edge_select[1] && edge_fall); // RULE5
  wire cap_fire = power_on && ctrl1_q.capture_input_enable &&
    src_valid && edge_hit; // RULE6

  // previous level follows even while disabled, so enabling never
  // produces a false edge from stale history
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sel_prev_q <= 1'b0;
    end else begin
      sel_prev_q <= sel_level;
    end
  end

  // ---------------------------------------------------------------
  // counter, compare and capture
  // ---------------------------------------------------------------
  wire cmp_equal = (cnt_q == cmp_q);
  wire match_hit = cnt_tick && cmp_equal; // RULE12
  wire match_clear = match_hit && ctrl1_q.clear_on_match;
  wire cap_clear = cap_fire && ctrl1_q.clear_on_capture;
  wire ovf_hit = cnt_tick && (cnt_q == `MCT_CNT_MAX) &&
    !match_clear && !cap_clear && !power_rise; // RULE10

  always_comb begin
    cnt_d = cnt_q;
    if (power_rise) begin
      cnt_d = `MCT_CNT_ZERO; // RULE17
    end else if (!power_on) begin
      cnt_d = cnt_q; // RULE17
    end else if (cap_clear) begin
      cnt_d = `MCT_CNT_ZERO; // RULE11
    end else if (match_clear) begin
      cnt_d = `MCT_CNT_ZERO; // RULE13
    end else if (cnt_tick) begin
      cnt_d = cnt_q + `MCT_CNT_ONE; // RULE8 RULE19
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cnt_q <= `MCT_CNT_ZERO;
      power_prev_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      power_prev_q <= power_on;
    end
  end

  // capture value has no meaning before the first capture
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cap_q <= `MCT_CNT_ZERO;
    end else if (cap_fire) begin
      cap_q <= cnt_q; // RULE9 RULE3
    end
  end

  // ---------------------------------------------------------------
  // software registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ctrl0_q <= `MCT_CTRL0_RST;
      ctrl1_q <= `MCT_CTRL1_RST;
      cmp_q <= `MCT_CNT_ZERO;
    end else begin
      if (wr_ctrl0) begin
        ctrl0_q <= wdata_i & `MCT_CTRL0_WMASK;
      end
      if (wr_ctrl1) begin
        ctrl1_q <= wdata_i;
      end
      if (wr_cmpl) begin
        cmp_q[7:0] <= wdata_i; // RULE2
      end
      if (wr_cmph) begin
        cmp_q[15:8] <= wdata_i; // RULE2
      end
    end
  end

  // flags clear by writing one; a new event in that cycle wins
  wire ovf_clr = wr_flags && wdata_i[`MCT_FLAG_OVF];
  wire match_clr = wr_flags && wdata_i[`MCT_FLAG_MATCH];

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ovf_flag_q <= 1'b0;
      match_flag_q <= 1'b0;
    end else begin
      ovf_flag_q <= ovf_hit || (ovf_flag_q && !ovf_clr); // RULE10
      match_flag_q <= match_hit || (match_flag_q && !match_clr); // RULE12
    end
  end

  always_comb begin
    rdata_d = `MCT_BYTE_ZERO;
    case (addr_i)
      `MCT_ADDR_CTRL0: rdata_d = ctrl0_q;
      `MCT_ADDR_CTRL1: rdata_d = ctrl1_q;
      `MCT_ADDR_CNTL: rdata_d = cnt_q[7:0];
      `MCT_ADDR_CNTH: rdata_d = cnt_q[15:8]; // RULE1
      `MCT_ADDR_CMPL: rdata_d = cmp_q[7:0];
      `MCT_ADDR_CMPH: rdata_d = cmp_q[15:8];
      `MCT_ADDR_CAPL: rdata_d = cap_q[7:0]; // RULE3
      `MCT_ADDR_CAPH: rdata_d = cap_q[15:8]; // RULE3
      `MCT_ADDR_FLAGS: rdata_d = {6'h00, match_flag_q, ovf_flag_q};
      default: rdata_d = `MCT_BYTE_ZERO;
    endcase
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rdata_q <= `MCT_BYTE_ZERO;
    end else begin
      rdata_q <= rd_i ? rdata_d : `MCT_BYTE_ZERO;
    end
  end

  assign rdata_o = rdata_q;
  assign counter_overflow_flag_o = ovf_flag_q;
  assign compare_match_flag_o = match_flag_q;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);

  chk_cnt_high_read: assert property ( // RULE1
    rd_i && addr_i == `MCT_ADDR_CNTH |=> rdata_o == $past(cnt_q[15:8]))
    else $error("counter high byte read wrong");

  chk_cmp_write: assert property ( // RULE2
    wr_cmph |=> cmp_q[15:8] == $past(wdata_i) && $stable(cmp_q[7:0]))
    else $error("compare high byte write wrong");

  chk_capture_copy: assert property ( // RULE9
    cap_fire |=> cap_q == $past(cnt_q))
    else $error("capture did not copy counter");

  chk_edge_off: assert property ( // RULE5
    ctrl1_q.capture_edge_select == MCT_EDGE_OFF |-> !cap_fire)
    else $error("capture fired with edges disabled");

  chk_src_reserved: assert property ( // RULE18
    ctrl0_q.capture_source_select == MCT_SRC_RSVD |-> !cap_fire)
    else $error("capture fired on reserved source");

  chk_capture_input_enable_gate: assert property ( // RULE6
    !ctrl1_q.capture_input_enable |=> $stable(cap_q))
    else $error("capture while capture input disabled");

  chk_overflow_flag: assert property ( // RULE10
    ovf_hit |=> counter_overflow_flag_o && cnt_q == `MCT_CNT_ZERO)
    else $error("overflow did not wrap and flag");

  chk_clear_capture: assert property ( // RULE11
    cap_clear && !power_rise |=> cnt_q == `MCT_CNT_ZERO)
    else $error("clear on capture failed");

  chk_match_flag: assert property ( // RULE12
    match_hit |=> compare_match_flag_o)
    else $error("match did not set flag");

  chk_match_clear: assert property ( // RULE13
    match_clear |=> cnt_q == `MCT_CNT_ZERO)
    else $error("clear on match failed");

  chk_pause_hold: assert property ( // RULE15
    power_on && ctrl0_q.counter_pause && !cap_clear && !power_rise
    |=> $stable(cnt_q))
    else $error("paused counter moved");

  chk_power_rise: assert property ( // RULE17
    power_rise |=> cnt_q == `MCT_CNT_ZERO)
    else $error("counter not zeroed on power up");

  chk_power_off: assert property ( // RULE17
    !power_on && !$past(power_on) |=> $stable(cnt_q))
    else $error("counter moved while off");

  chk_count_step: assert property ( // RULE8
    cnt_tick && !match_clear && !cap_clear && !power_rise
    |=> cnt_q == $past(cnt_q) + `MCT_CNT_ONE)
    else $error("counter did not advance by one");

  chk_div_two: assert property ( // RULE16
    cnt_tick && ctrl0_q.counter_clock_select == 3'h1
    && $stable(ctrl0_q) |=> !pre_tick)
    else $error("divide by two ticked twice in a row");

  chk_ovf_at_max: assert property ( // RULE10
    $rose(counter_overflow_flag_o) |-> $past(cnt_q) == `MCT_CNT_MAX)
    else $error("overflow flag rose away from all ones");

  chk_match_equal: assert property ( // RULE12
    $rose(compare_match_flag_o) |-> $past(cnt_q) == $past(cmp_q))
    else $error("match flag rose without equal count");

  chk_ovf_clear: assert property ( // RULE10
    ovf_clr && !ovf_hit |=> !counter_overflow_flag_o)
    else $error("overflow flag survived its clear");

endmodule
`default_nettype wire

// [mct_sensor_model.sv]
// rotor position sensor model driving the three capture inputs
`timescale 1ns/1ps
`default_nettype none
module mct_sensor_model (
  input wire logic clk_i,
  input wire logic set_i,
  input wire logic [2:0] level_i,
  input wire logic [2:0] glitch_i,
  input wire logic [2:0] width_i,
  output logic [2:0] pos_o
);
  logic [2:0] hold_q = 3'h0;
  logic [2:0] mask_q = 3'h0;
  logic [2:0] left_q = 3'h0;
  // lines only move just after an edge, like a real sensor stage
  always @(posedge clk_i) begin
    if (set_i) begin
      hold_q <= level_i;
      mask_q <= glitch_i;
      left_q <= width_i;
    end else if (left_q != 3'h0) begin
      left_q <= left_q - 3'h1;
    end
  end
  // a glitch inverts the masked lines for width cycles, then lets go
  assign pos_o = (left_q != 3'h0) ? (hold_q ^ mask_q) : hold_q;
endmodule
`default_nettype wire

// [testbench.sv]
// self-checking bench for the motor capture/compare timer
`timescale 1ns/1ps
`default_nettype none
`include "mct_regs.svh"
module testbench;
  import mct_pkg::*;
  localparam logic [3:0] C0 = `MCT_ADDR_CTRL0;
  localparam logic [3:0] C1 = `MCT_ADDR_CTRL1;
  localparam logic [3:0] CL = `MCT_ADDR_CNTL;
  localparam logic [3:0] FL = `MCT_ADDR_FLAGS;
  logic clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] rdata;
  logic ovf;
  logic match;
  logic set = 1'b0;
  logic [2:0] lvl = 3'h0;
  logic [2:0] gl = 3'h0;
  logic [2:0] wd = 3'h0;
  logic [2:0] pos;
  int mismatches = 0;
  int n_compared = 0;
  logic [15:0] v;
  logic [15:0] u;
  int k;

  mct_timer mct_timer_i (.clk_i(clk_i), .reset_n_i(reset_n_i), .addr_i(addr),
    .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata),
    .position_input_a_i(pos[0]), .position_input_b_i(pos[1]),
    .position_input_c_i(pos[2]), .counter_overflow_flag_o(ovf),
    .compare_match_flag_o(match));
  mct_sensor_model mct_sensor_model_i (.clk_i(clk_i), .set_i(set),
    .level_i(lvl), .glitch_i(gl), .width_i(wd), .pos_o(pos));

  initial begin
    forever #20 clk_i = ~clk_i;
  end

  task automatic complete_run;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk_i);
    wr <= 1'b0;
  endtask

  // data stands only in the cycle after the strobe
  task automatic rd_reg(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk_i);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_i);
    rd <= 1'b0;
    @(negedge clk_i);
    d = rdata;
  endtask

  task automatic capv(output logic [15:0] c);
    rd_reg(`MCT_ADDR_CAPL, c[7:0]);
    rd_reg(`MCT_ADDR_CAPH, c[15:8]);
  endtask

  task automatic pins(input logic [2:0] l, input logic [2:0] g,
                      input logic [2:0] w);
    @(posedge clk_i);
    set <= 1'b1;
    lvl <= l;
    gl <= g;
    wd <= w;
    @(posedge clk_i);
    set <= 1'b0;
  endtask

  // accepts e up to e + tol; unknowns always fail
  task automatic chk(input string n, input logic [15:0] e,
                     input logic [15:0] g, input logic [15:0] tol);
    n_compared++;
    if ((^g) === 1'bx || g < e || 17'(g) > 17'(e) + 17'(tol)) begin
      mismatches++;
      $display("wrong value %s expected %0d seen %0d", n, e, g);
    end
  endtask

  task automatic wait_flag(input logic sel, input int lim);
    int i;
    for (i = 0; i < lim; i++) begin
      @(negedge clk_i);
      if ((sel ? match : ovf) === 1'b1) break;
    end
    chk("flag", 16'h0001, {15'h0000, sel ? match : ovf}, 16'h0000);
    if (i == lim) complete_run();
  endtask

  // edges at 0 rise, 50 fall, 80 rise, 110 fall
  task automatic seq_mode;
    pins(3'h7, 3'h0, 3'h0);
    cyc(48);
    pins(3'h0, 3'h0, 3'h0);
    cyc(28);
    pins(3'h7, 3'h0, 3'h0);
    cyc(28);
    pins(3'h0, 3'h0, 3'h0);
    cyc(12);
  endtask

  initial begin
    cyc(10);
    reset_n_i <= 1'b1;
    for (k = 0; k < 10; k++) begin
      if (k != 6 && k != 7) begin
        rd_reg(4'(k), v[7:0]);
        chk("reset value", 16'h0000, {8'h00, v[7:0]}, 16'h0000);
      end
    end
    wr_reg(`MCT_ADDR_CNTH, 8'hFF);
    rd_reg(`MCT_ADDR_CNTH, v[7:0]);
    chk("count high", 16'h0000, {8'h00, v[7:0]}, 16'h0000);
    wr_reg(`MCT_ADDR_CMPL, 8'hA5);
    wr_reg(`MCT_ADDR_CMPH, 8'h5A);
    rd_reg(`MCT_ADDR_CMPL, v[7:0]);
    rd_reg(`MCT_ADDR_CMPH, v[15:8]);
    chk("compare", 16'h5AA5, v, 16'h0000);
    $display("registers done");

    for (k = 0; k < 8; k++) begin
      wr_reg(C0, {1'b0, 3'(k), 4'h8});
      cyc(4);
      rd_reg(CL, v[7:0]);
      cyc(126);
      rd_reg(CL, u[7:0]);
      u[7:0] = u[7:0] - v[7:0];
      chk("ticks", 16'(128 >> k), {8'h00, u[7:0]}, 16'h0000);
    end
    $display("clock select done");

    wr_reg(C0, 8'h88);
    rd_reg(CL, v[7:0]);
    cyc(20);
    rd_reg(CL, u[7:0]);
    chk("paused", 16'h0000, {8'h00, u[7:0] - v[7:0]}, 16'h0000);
    wr_reg(C0, 8'h08);
    rd_reg(CL, u[7:0]);
    chk("resume", 16'h0000, {8'h00, u[7:0] - v[7:0]}, 16'h0003);
    wr_reg(C0, 8'h00);
    rd_reg(CL, v[7:0]);
    cyc(20);
    rd_reg(CL, u[7:0]);
    chk("off hold", 16'h0000, {8'h00, u[7:0] - v[7:0]}, 16'h0000);
    $display("pause done");

    // stall limit programmed while off, so the restart begins below it
    wr_reg(`MCT_ADDR_CMPH, 8'h00);
    wr_reg(`MCT_ADDR_CMPL, 8'h09);
    wr_reg(C1, 8'h01);
    wr_reg(FL, 8'h03);
    wr_reg(C0, 8'h08);
    rd_reg(CL, v[7:0]);
    chk("restart", 16'h0000, {8'h00, v[7:0]}, 16'h0004);
    wait_flag(1'b1, 40);
    for (k = 0; k < 6; k++) begin
      rd_reg(CL, v[7:0]);
      chk("cleared count", 16'h0000, {8'h00, v[7:0]}, 16'h0009);
    end
    wr_reg(C0, 8'h88);
    wr_reg(FL, 8'h02);
    cyc(4);
    @(negedge clk_i);
    chk("match clear", 16'h0000, {15'h0000, match}, 16'h0000);
    chk("no overflow", 16'h0000, {15'h0000, ovf}, 16'h0000);
    wr_reg(C0, 8'h08);
    wait_flag(1'b1, 40);
    $display("compare done");

    wr_reg(C1, 8'h00);
    wr_reg(`MCT_ADDR_CMPH, 8'hFF);
    wr_reg(`MCT_ADDR_CMPL, 8'hFF);
    wr_reg(FL, 8'h03);
    wait_flag(1'b0, 66000);
    chk("top match", 16'h0001, {15'h0000, match}, 16'h0000);
    rd_reg(`MCT_ADDR_CNTH, v[7:0]);
    chk("wrapped", 16'h0000, {8'h00, v[7:0]}, 16'h0000);
    $display("overflow done");

    for (k = 1; k < 4; k++) begin
      wr_reg(C1, {2'(k), 6'h22});
      seq_mode();
      capv(v);
      u = k == 1 ? 16'h004F : k == 2 ? 16'h003B : 16'h001D;
      chk("capture", u, v, 16'h0001);
    end
    wr_reg(C1, 8'h22);
    seq_mode();
    capv(u);
    chk("edge off", v, u, 16'h0000);
    wr_reg(C1, 8'h42);
    seq_mode();
    capv(u);
    chk("input off", v, u, 16'h0000);
    wr_reg(C0, 8'h0B);
    wr_reg(C1, 8'h62);
    seq_mode();
    capv(u);
    chk("reserved source", v, u, 16'h0000);
    $display("capture done");

    // only the selected line rises early; the others rise 20 later
    for (k = 0; k < 3; k++) begin
      wr_reg(C0, {6'h02, 2'(k)});
      pins(3'h7, 3'h0, 3'h0);
      cyc(18);
      pins(3'h0, 3'h0, 3'h0);
      cyc(18);
      pins(3'h1 << k, 3'h0, 3'h0);
      cyc(18);
      pins(3'h7, 3'h0, 3'h0);
      cyc(18);
      pins(3'h0, 3'h0, 3'h0);
      cyc(12);
      capv(v);
      chk("source", 16'h0027, v, 16'h0001);
    end
    $display("source done");

    wr_reg(C0, 8'h08);
    wr_reg(C1, 8'h7E);
    seq_mode();
    capv(v);
    chk("filtered", 16'h004F, v, 16'h0001);
    pins(3'h0, 3'h7, 3'h7);
    cyc(40);
    capv(u);
    chk("slow glitch", v, u, 16'h0000);
    wr_reg(C1, 8'h66);
    pins(3'h0, 3'h7, 3'h1);
    cyc(20);
    capv(u);
    chk("fast glitch", v, u, 16'h0000);
    wr_reg(C1, 8'h62);
    pins(3'h0, 3'h7, 3'h1);
    cyc(20);
    capv(u);
    chk("unfiltered", 16'h0064, u, 16'hFF00);
    $display("filter done");
    complete_run();
  end
endmodule
`default_nettype wire
